// *** reset_strap_and_master_clock_setup.sv ***
`timescale 1ns/1ps
// How it works
// (RULE_01) capture five straps when reset pin rises
// (RULE_02) after capture straps become run-time pins
// (RULE_03) factory strap high selects manufacturing test
// (RULE_04) test with autoconfig 00 allows eeprom programming
// (RULE_05) host select 00-10 gives I2C address
// (RULE_06) host select 11 gives SPI slave
// (RULE_07) autoconfig straps index stored configuration
// (RULE_08) board holds reset low long enough
// (RULE_09) mode 10 enables single-ended oscillator input
// (RULE_10) mode 01 enables crystal driver
// (RULE_11) doubler bit routes oscillator through doubler
// (RULE_12) software programs master clock frequency
// (RULE_13) software avoids doubler with oscillator attenuating
// (RULE_14) software trims offset or feedback divider
// (RULE_15) master clock near 100/114.285/125 MHz
// (RULE_16) software selects oscillator once stable
// (RULE_17) capture status read-only until next release
module reset_strap_and_master_clock_setup
    import strap_cfg_pkg::*;
#(
    parameter bit CHANNEL_B = 1'b0,  // selects upper I2C address bits
    parameter int FREQ_W = 4,        // width of master clock frequency field
    parameter int OFFSET_W = 32,     // width of dpll frequency offset
    parameter int FBDIV_W = 40       // width of apll feedback divider
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    // reset pin and strap pins, asynchronous to clk_in
    input wire logic reset_pin_low_in,
    input wire logic factory_check_in,
    input wire logic autoconfig_select_hi_in,
    input wire logic autoconfig_select_lo_in,
    input wire logic host_port_select_hi_in,
    input wire logic host_port_select_lo_in,
    // run-time roles of the strap pins
    input wire logic [2:0] gpio_drive_in,
    input wire logic [2:0] gpio_oe_in,
    input wire logic spi_data_out_in,
    input wire logic spi_data_oe_in,
    output logic [2:0] gpio_pin_out,
    output logic [2:0] gpio_pin_oe_out,
    output logic spi_data_pin_out,
    output logic spi_data_pin_oe_out,
    output logic spi_chip_select_out,
    // capture results
    output logic [4:0] strap_capture_status_out,
    output logic straps_captured_out,
    output logic test_mode_out,
    output logic [1:0] test_mode_select_out,
    output logic eeprom_prog_enable_out,
    output logic host_spi_mode_out,
    output logic host_i2c_mode_out,
    output logic [6:0] i2c_slave_address_out,
    output logic [1:0] autoconfig_index_out,
    output logic autoconfig_start_out,
    // master clock control
    input wire logic [1:0] osc_input_mode_in,
    input wire logic doubler_enable_in,
    input wire logic master_clock_select_in,
    input wire logic [FREQ_W-1:0] master_clock_freq_in,
    input wire logic [OFFSET_W-1:0] dpll_freq_offset_in,
    input wire logic [FBDIV_W-1:0] apll_feedback_divider_in,
    output logic osc_single_ended_enable_out,
    output logic crystal_driver_enable_out,
    output logic doubler_path_enable_out,
    output logic dpll_clock_from_osc_out,
    output logic [FREQ_W-1:0] master_clock_freq_out,
    output logic [OFFSET_W-1:0] dpll_freq_offset_out,
    output logic [FBDIV_W-1:0] apll_feedback_divider_out
);
    // ==========================================
    // synchronise pins
    // ==========================================
    // the reset pin rides in the same synchroniser as the straps, so both
    // reach the capture logic with the same delay
    logic [5:0] raw_pins;   // reset pin on top of the five straps
    logic [5:0] sync_pins;  // filtered copies
    assign raw_pins = {reset_pin_low_in, factory_check_in, autoconfig_select_hi_in,
                       autoconfig_select_lo_in, host_port_select_hi_in,
                       host_port_select_lo_in};

    strap_pin_sync #(
        .WIDTH(6)
    ) strap_pin_sync_i (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(raw_pins),
        .level_out(sync_pins)
    );

    // ==========================================
    // capture on reset pin release
    // ==========================================
    logic reset_pin_prev;   // last filtered reset pin level
    logic [4:0] strap;      // captured straps
    logic captured;         // straps have been captured since last release
    logic start_pulse;      // one-cycle autoconfig start
    wire reset_pin_level = sync_pins[5];                    // filtered pin, high = running
    wire [4:0] strap_level = sync_pins[4:0];                // filtered strap levels
    wire release_edge = reset_pin_level & ~reset_pin_prev;  // pin has just gone high
    wire reset_pin_held = ~reset_pin_level;                 // pin still holds the channel

    // edge tracker for the reset pin; the previous level resets low like the
    // pin at power-up, so a pin already high when the core reset lifts still
    // counts as one release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            reset_pin_prev <= 1'b0;
            start_pulse <= 1'b0;
        end else begin
            reset_pin_prev <= reset_pin_level;
            start_pulse <= release_edge;        // high in the first captured cycle
        end
    end

    // the straps share filter delay with the reset pin, so the sample
    // at the release edge shows the levels as they stood at the pin edge;
    // board straps settle long before release when the pulse is wide
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap <= STRAP_RESET_VAL;
            captured <= 1'b0;
        end else if (reset_pin_held) begin
            captured <= 1'b0;                   // pin held low: roles back to straps
        end else if (release_edge) begin
            strap <= strap_level;               // see RULE_01, see RULE_17
            captured <= 1'b1;                   // run-time roles take the pins
        end
    end

    // ==========================================
    // decode of captured straps
    // ==========================================
    wire [1:0] host_sel = {strap[STRAP_HOST_HI_POS], strap[STRAP_HOST_LO_POS]};
    wire [1:0] ac_sel = {strap[STRAP_AC_HI_POS], strap[STRAP_AC_LO_POS]};
    wire test_sel = strap[STRAP_TEST_POS];
    wire [4:0] i2c_upper = CHANNEL_B ? I2C_UPPER_CH_B : I2C_UPPER_CH_A; // fixed per channel
    wire host_is_spi = (host_sel == HOST_SEL_SPI);          // both host selects high
    wire ac_is_prog = (ac_sel == TEST_EEPROM_PROG);         // test mode for eeprom programming
    wire test_active = captured & test_sel;                 // manufacturing test after capture

    // the test, eeprom and host mode decodes are gated by captured so that none acts on an old
    // status while the pin holds the channel in reset; the test select, address and index are not gated
    assign strap_capture_status_out = strap;                        // see RULE_17
    assign straps_captured_out = captured;
    assign test_mode_out = test_active;                             // see RULE_03
    assign test_mode_select_out = ac_sel;                           // see RULE_03
    assign eeprom_prog_enable_out = test_active & ac_is_prog;       // see RULE_04
    assign host_spi_mode_out = captured & host_is_spi;              // see RULE_06
    assign host_i2c_mode_out = captured & ~host_is_spi;             // see RULE_05
    assign i2c_slave_address_out = {i2c_upper, host_sel};          // see RULE_05
    assign autoconfig_index_out = ac_sel;                           // see RULE_07
    // no stored configuration runs while a test mode is active; only the
    // captured strap decides, the pin already serves its run-time role
    assign autoconfig_start_out = start_pulse & ~test_sel;          // see RULE_07

    // ==========================================
    // run-time pin roles
    // ==========================================
    // drivers stay off until capture so board straps are not fought;
    // the trade is a pin left undriven for a few cycles after release
    wire chip_select_low = ~sync_pins[STRAP_HOST_LO_POS];       // chip select pin is active low
    wire spi_out_allowed = host_spi_mode_out & spi_data_oe_in;  // data out only as spi slave

    assign gpio_pin_out = gpio_drive_in;
    // one enable gate per general-purpose pin
    for (genvar g = 0; g < 3; g++) begin : g_gpio_oe
        assign gpio_pin_oe_out[g] = captured & gpio_oe_in[g];   // see RULE_02
    end
    assign spi_data_pin_out = spi_data_out_in;
    assign spi_data_pin_oe_out = spi_out_allowed;                     // see RULE_02
    // chip select input only counts once the pin has its run-time role
    assign spi_chip_select_out = host_spi_mode_out & chip_select_low; // see RULE_02

    // ==========================================
    // master clock control
    // ==========================================
    wire osc_se = (osc_input_mode_in == OSC_MODE_SINGLE_ENDED); // oscillator pin as clock input
    wire osc_xtal = (osc_input_mode_in == OSC_MODE_CRYSTAL);     // crystal driver across pins
    wire osc_source = osc_se | osc_xtal;                         // some source feeds the doubler
    wire doubler_on = doubler_enable_in & osc_source;            // doubler has a signal to double

    // registered so the analog enables never glitch on a field rewrite;
    // modes 00 and 11 leave both the input and the driver off
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_single_ended_enable_out <= 1'b0;
            crystal_driver_enable_out <= 1'b0;
            doubler_path_enable_out <= 1'b0;
        end else begin
            osc_single_ended_enable_out <= osc_se;      // see RULE_09
            crystal_driver_enable_out <= osc_xtal;      // see RULE_10
            doubler_path_enable_out <= doubler_on;      // see RULE_11
        end
    end

    // master clock source and declared frequency; software must move the
    // source to the oscillator pin only once that oscillator has settled
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dpll_clock_from_osc_out <= 1'b0;
            master_clock_freq_out <= '0;
        end else begin
            dpll_clock_from_osc_out <= master_clock_select_in;  // see RULE_16
            master_clock_freq_out <= master_clock_freq_in;      // see RULE_12
        end
    end

    // frequency trims pass straight through; the block does not check them
    // against the chosen pll mode, that choice belongs to software
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dpll_freq_offset_out <= '0;
            apll_feedback_divider_out <= '0;
        end else begin
            dpll_freq_offset_out <= dpll_freq_offset_in;            // see RULE_14
            apll_feedback_divider_out <= apll_feedback_divider_in;  // see RULE_14
        end
    end
endmodule

// *** reset_strap_and_master_clock_setup_properties.sv ***
`timescale 1ns/1ps
// ==========================================
// port checker for strap capture and clock setup
// ==========================================
module reset_strap_and_master_clock_setup_properties
    import strap_cfg_pkg::*;
#(
    parameter bit CHANNEL_B = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reset_pin_low_in,
    input wire logic [1:0] osc_input_mode_in,
    input wire logic doubler_enable_in,
    input wire logic [4:0] strap_capture_status_out,
    input wire logic straps_captured_out,
    input wire logic test_mode_out,
    input wire logic eeprom_prog_enable_out,
    input wire logic host_spi_mode_out,
    input wire logic host_i2c_mode_out,
    input wire logic [6:0] i2c_slave_address_out,
    input wire logic [1:0] autoconfig_index_out,
    input wire logic autoconfig_start_out,
    input wire logic [2:0] gpio_pin_oe_out,
    input wire logic osc_single_ended_enable_out,
    input wire logic crystal_driver_enable_out,
    input wire logic doubler_path_enable_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // captured fields, named for readability
    wire logic [1:0] host = strap_capture_status_out[1:0];
    wire logic [1:0] ac = strap_capture_status_out[3:2];
    wire logic [4:0] upper = CHANNEL_B ? I2C_UPPER_CH_B : I2C_UPPER_CH_A;
    // start pulse: in the first cycle with captured straps, one cycle wide
    sequence s_release;
        $rose(straps_captured_out);
    endsequence
    sequence s_start_pulse;
        (autoconfig_start_out == !strap_capture_status_out[4]) ##1 !autoconfig_start_out;
    endsequence
    AST_CAPTURE: assert property ($rose(reset_pin_low_in) |-> ##[1:8] straps_captured_out)
        else $error("straps not captured after reset pin release");
    AST_HOLD: assert property (straps_captured_out && $past(straps_captured_out) |->
        $stable(strap_capture_status_out)) else $error("capture status changed");
    AST_OE: assert property (!straps_captured_out |-> gpio_pin_oe_out == 3'h0)
        else $error("pin driven before capture");
    AST_TEST: assert property (straps_captured_out |-> test_mode_out == strap_capture_status_out[4])
        else $error("test mode mismatch");
    AST_EEPROM: assert property (straps_captured_out |-> eeprom_prog_enable_out ==
        (strap_capture_status_out[4] && ac == TEST_EEPROM_PROG)) else $error("eeprom mode mismatch");
    AST_I2C: assert property (host_i2c_mode_out |-> i2c_slave_address_out == {upper, host})
        else $error("slave address mismatch");
    AST_SPI: assert property (straps_captured_out |-> host_spi_mode_out == (host == HOST_SEL_SPI)
        && host_i2c_mode_out == (host != HOST_SEL_SPI)) else $error("interface mode mismatch");
    AST_INDEX: assert property (straps_captured_out |-> autoconfig_index_out == ac)
        else $error("config index mismatch");
    AST_START: assert property (s_release |-> s_start_pulse)
        else $error("start pulse wrong");
    AST_SE: assert property (osc_input_mode_in == OSC_MODE_SINGLE_ENDED |=> osc_single_ended_enable_out)
        else $error("single-ended input not enabled");
    AST_XTAL: assert property (osc_input_mode_in == OSC_MODE_CRYSTAL |=> crystal_driver_enable_out
        && !osc_single_ended_enable_out) else $error("crystal driver not enabled");
    AST_DBL: assert property (doubler_enable_in && osc_input_mode_in inside {2'h1, 2'h2}
        |=> doubler_path_enable_out) else $error("doubler not enabled");
endmodule

bind reset_strap_and_master_clock_setup reset_strap_and_master_clock_setup_properties
    #(.CHANNEL_B(CHANNEL_B)) checker_i (.clk_in, .rst_n_in, .reset_pin_low_in,
    .osc_input_mode_in, .doubler_enable_in, .strap_capture_status_out, .straps_captured_out,
    .test_mode_out, .eeprom_prog_enable_out, .host_spi_mode_out, .host_i2c_mode_out,
    .i2c_slave_address_out, .autoconfig_index_out, .autoconfig_start_out, .gpio_pin_oe_out,
    .osc_single_ended_enable_out, .crystal_driver_enable_out, .doubler_path_enable_out);

// *** reset_strap_and_master_clock_setup_tb.sv ***
`timescale 1ns/1ps
module reset_strap_and_master_clock_setup_tb;
    logic clk_in, rst_n_in, go, rpin, dbl, spi_pin, spi_oe, spi_cs, captured, test, eeprom;
    logic spi_mode, i2c_mode, start, se, xtal, dpath, from_osc;
    logic [4:0] straps, pins, status;
    logic [1:0] osc_mode, tsel, index;
    logic [2:0] gpio_pin, gpio_oe;
    logic [6:0] addr;
    logic [3:0] freq, freq_o;
    logic [31:0] offs, offs_o;
    logic [39:0] fbdiv, fbdiv_o;
    int errors, n_compared, pulses;
    strap_board_model strap_board_model_i (.clk_in, .go_in(go), .straps_in(straps),
        .reset_pin_low_out(rpin), .pins_out(pins));
    reset_strap_and_master_clock_setup reset_strap_and_master_clock_setup_i (.clk_in, .rst_n_in,
        .reset_pin_low_in(rpin), .factory_check_in(pins[4]), .autoconfig_select_hi_in(pins[3]),
        .autoconfig_select_lo_in(pins[2]), .host_port_select_hi_in(pins[1]),
        .host_port_select_lo_in(pins[0]), .gpio_drive_in(3'h5), .gpio_oe_in(3'h6),
        .spi_data_out_in(1'b1), .spi_data_oe_in(1'b1), .gpio_pin_out(gpio_pin),
        .gpio_pin_oe_out(gpio_oe), .spi_data_pin_out(spi_pin), .spi_data_pin_oe_out(spi_oe),
        .spi_chip_select_out(spi_cs), .strap_capture_status_out(status),
        .straps_captured_out(captured), .test_mode_out(test), .test_mode_select_out(tsel),
        .eeprom_prog_enable_out(eeprom), .host_spi_mode_out(spi_mode),
        .host_i2c_mode_out(i2c_mode), .i2c_slave_address_out(addr),
        .autoconfig_index_out(index), .autoconfig_start_out(start),
        .osc_input_mode_in(osc_mode), .doubler_enable_in(dbl), .master_clock_select_in(dbl),
        .master_clock_freq_in(freq), .dpll_freq_offset_in(offs), .apll_feedback_divider_in(fbdiv),
        .osc_single_ended_enable_out(se), .crystal_driver_enable_out(xtal),
        .doubler_path_enable_out(dpath), .dpll_clock_from_osc_out(from_osc),
        .master_clock_freq_out(freq_o), .dpll_freq_offset_out(offs_o),
        .apll_feedback_divider_out(fbdiv_o));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in; // nominal 100 MHz master clock
    end
    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task report_and_stop;
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one reset pin pulse with the given straps, then the pins are overdriven
    task automatic capture(input logic [4:0] s);
        @(posedge clk_in);
        pulses = 0;
        straps <= s;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_in);
            #1;
            if (start === 1'b1) pulses++;
            if (i == 10) chk("oe early", gpio_oe, 3'h0);
        end
        chk("status", status, s);
        chk("captured", captured, 1'b1);
        chk("test", {test, tsel}, s[4:2]);
        chk("eeprom", eeprom, s[4] && s[3:2] == 2'h0);
        chk("i2c", i2c_mode, s[1:0] != 2'h3);
        if (s[1:0] != 2'h3) chk("addr", addr, {5'h10, s[1:0]});
        chk("spi", {spi_mode, spi_oe, spi_cs}, {3{s[1:0] == 2'h3}});
        chk("index", index, s[3:2]);
        chk("start", pulses, !s[4]);
        chk("pins", {spi_pin, gpio_oe, gpio_pin}, 7'h75);
    endtask
    // clock source settings take effect one cycle later
    task automatic osc(input logic [1:0] m, input logic d);
        @(posedge clk_in);
        osc_mode <= m;
        dbl <= d; // doubler with an oscillator only as in nco mode
        freq <= {m, d, 1'b1};
        offs <= 32'h12345678 + m;
        fbdiv <= 40'h123456789A + d;
        repeat (2) @(posedge clk_in);
        #1;
        chk("se", se, m == 2'h2);
        chk("xtal", xtal, m == 2'h1);
        chk("dbl", dpath, d && (m == 2'h1 || m == 2'h2));
        chk("freq", {from_osc, freq_o}, {d, m, d, 1'b1});
        chk("offset", offs_o, 32'h12345678 + m);
        chk("divider", fbdiv_o, 40'h123456789A + d);
    endtask
    initial begin
        rst_n_in = 1'b0;
        {go, straps, osc_mode, dbl, freq, offs, fbdiv, errors, n_compared} = '0;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int s = 0; s < 32; s++) capture(s[4:0]);
        for (int m = 0; m < 8; m++) osc(m[1:0], m[2]);
        report_and_stop();
    end
    // hang guard, far beyond the roughly 1400 cycles the tests need
    initial begin
        #100us;
        errors++;
        report_and_stop();
    end
endmodule

// *** strap_board_model.sv ***
`timescale 1ns/1ps
// ==========================================
// board straps and reset source
// ==========================================
module strap_board_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic [4:0] straps_in,
    output logic reset_pin_low_out,
    output logic [4:0] pins_out
);
    int cnt = 40;               // idle until the first go
    logic rpin = 1'b0;          // reset pin level, low at power-up
    logic [4:0] pins = 5'h00;   // levels on the five strap pins
    assign reset_pin_low_out = rpin;
    assign pins_out = pins;
    // straps settle with reset low; release after 9 cycles, well past the minimum width
    always @(posedge clk_in) begin
        if (go_in) begin
            cnt <= 0;
            rpin <= 1'b0;
            pins <= straps_in;
        end else if (cnt < 40) begin
            cnt <= cnt + 1;
            if (cnt == 8) rpin <= 1'b1;
            // run-time drivers then take the pins, so late levels differ from the straps
            if (cnt == 20) pins <= ~straps_in;
        end
    end
endmodule

// *** strap_cfg_pkg.sv ***
package strap_cfg_pkg;
    // ==========================================
    // strap capture layout
    // ==========================================
    localparam int STRAP_W = 5;                       // number of strap pins
    localparam int STRAP_HOST_LO_POS = 0;             // host port select lo
    localparam int STRAP_HOST_HI_POS = 1;             // host port select hi
    localparam int STRAP_AC_LO_POS = 2;               // autoconfig select lo
    localparam int STRAP_AC_HI_POS = 3;               // autoconfig select hi
    localparam int STRAP_TEST_POS = 4;                // factory check strap
    localparam logic [4:0] STRAP_RESET_VAL = 5'h00;   // status before first capture

    // ==========================================
    // processor interface
    // ==========================================
    localparam logic [1:0] HOST_SEL_SPI = 2'h3;       // both selects high
    localparam logic [4:0] I2C_UPPER_CH_A = 5'h10;    // upper address bits, channel A
    localparam logic [4:0] I2C_UPPER_CH_B = 5'h11;    // upper address bits, channel B
    localparam logic [1:0] TEST_EEPROM_PROG = 2'h0;   // test mode for eeprom programming

    // ==========================================
    // oscillator control
    // ==========================================
    localparam logic [1:0] OSC_MODE_SINGLE_ENDED = 2'h2;
    localparam logic [1:0] OSC_MODE_CRYSTAL = 2'h1;

    // ==========================================
    // pin synchroniser
    // ==========================================
    localparam int SYNC_STAGES = 3;
endpackage

// *** strap_pin_sync.sv ***
`timescale 1ns/1ps
// ==========================================
// three-stage synchroniser with agreement filter
// ==========================================
module strap_pin_sync
    import strap_cfg_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1; // metastability catcher, read only by stage2
    logic [WIDTH-1:0] stage2; // second stage
    logic [WIDTH-1:0] stage3; // third stage
    logic [WIDTH-1:0] level;  // filtered level
    wire [WIDTH-1:0] agree = ~(stage2 ^ stage3); // a change counts once 2 and 3 agree

    // shift chain and filtered level
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= (agree & stage3) | (~agree & level);
        end
    end

    assign level_out = level;
endmodule
